// >>> design/stm_timer.sv
// design: sixteen-bit standard timer with apb register access and two output pins
// Summary of operation
// - writing compare low byte loads only the shared holding buffer
// - high byte write stores directly and copies buffer into paired low byte
// - high byte read returns it and captures paired low byte into buffer
// - low byte read returns the holding buffer, not the live byte
// - counter is sixteen bits, counts up on the selected clock tick
// - period value compares with counter upper byte only
// - compare value compares with all sixteen counter bits
// - software cannot write the counter; on bit rising clears it
// - counter clears on overflow or selected comparator match
// - both comparator matches raise the timer interrupt request pulse, clearing or not
// - pause bit holds count; clearing it resumes from held value
// - clock select picks sys/4, sys, h/16, h/64, time base, pin edges
// - on bit low stops counting and keeps count; rise clears counter
// - in compare output mode on bit rise restores initial output level
// - control 0 bits 2 to 0 read as zero
// - mode field: compare output, capture, pwm/single pulse, timer/counter
// - two output pins carry same signal or one inverted copy
// - compare match in compare output mode: none, low, high, toggle
// - clear select 1 clears on compare match, 0 on period match/overflow
// - period zero gives 65536 clocks, N gives 256 times N clocks
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module stm_timer
	import stm_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              fh_tick,
	input  wire logic              time_base_clock,
	input  wire logic              external_clock_pin,
	output logic                   timer_output_pin_a,
	output logic                   timer_output_pin_b,
	output logic                   timer_irq,
	output logic                   cmp_a_match,
	output logic                   cmp_p_match
);
	// address decode shared by setup and access phases
	function automatic logic map_ok(input logic [ADDR_W-1:0] a);
		map_ok = (a[1:0] == WORD_LSB) && (a[ADDR_W-1:5] == '0);
	endfunction
	function automatic logic [2:0] map_idx(input logic [ADDR_W-1:0] a);
		map_idx = a[4:2];
	endfunction

	stm_ctrl0_s  ctrl0_ff, nxt_ctrl0;
	stm_ctrl1_s  ctrl1_ff, nxt_ctrl1;
	logic [15:0] cmp_ff, nxt_cmp;
	logic [7:0]  period_ff, nxt_period;
	logic [7:0]  buf_ff, nxt_buf;
	logic        pin_b_inv_ff, nxt_pin_b_inv;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        err_ff, nxt_err;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [1:0]  div4_ff, nxt_div4;
	logic [5:0]  divh_ff, nxt_divh;
	logic        pin_d_ff, nxt_pin_d;
	logic        on_prev_ff, nxt_on_prev;
	logic        out_ff, nxt_out;
	logic        irq_ff, nxt_irq;
	logic        am_ff, nxt_am;
	logic        pm_ff, nxt_pm;

	logic        setup, wr_acc, rd_acc, on_rise, tick, run, a_hit, p_hit, do_clr;
	logic [2:0]  idx;
	logic [15:0] cnt_inc;

	// all checks below share the register clock and stand down during reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pwrite && map_ok(paddr);
	assign rd_acc  = psel && penable && !pwrite && map_ok(paddr);
	assign idx     = map_idx(paddr);
	assign pready  = 1'b1; // registers answer with no wait state
	assign prdata  = prdata_ff;
	assign pslverr = err_ff;

	// register file, shared holding buffer and read data
	always_comb begin
		nxt_ctrl0     = ctrl0_ff;
		nxt_ctrl1     = ctrl1_ff;
		nxt_cmp       = cmp_ff;
		nxt_period    = period_ff;
		nxt_buf       = buf_ff;
		nxt_pin_b_inv = pin_b_inv_ff;
		nxt_prdata    = prdata_ff;
		nxt_err       = err_ff;
		if (setup) begin
			// read data is sampled in setup so it leaves a flip-flop
			nxt_err    = !map_ok(paddr);
			nxt_prdata = '0;
			if (!map_ok(paddr)) begin
				nxt_prdata = '0;
			end else if (idx == IDX_CTRL0) begin
				nxt_prdata[7:0] = {ctrl0_ff[7:3], RSVD_ZERO};
			end else if (idx == IDX_CTRL1) begin
				nxt_prdata[7:0] = ctrl1_ff;
			end else if (idx == IDX_CNT_LO || idx == IDX_CMP_LO) begin
				nxt_prdata[7:0] = buf_ff;
			end else if (idx == IDX_CNT_HI) begin
				nxt_prdata[7:0] = cnt_ff[15:8];
			end else if (idx == IDX_CMP_HI) begin
				nxt_prdata[7:0] = cmp_ff[15:8];
			end else if (idx == IDX_PERIOD) begin
				nxt_prdata[7:0] = period_ff;
			end else begin
				nxt_prdata[0] = pin_b_inv_ff;
			end
		end
		if (wr_acc) begin
			if (idx == IDX_CTRL0) begin
				nxt_ctrl0      = pwdata[7:0];
				nxt_ctrl0.rsvd = RSVD_ZERO;
			end else if (idx == IDX_CTRL1) begin
				nxt_ctrl1 = pwdata[7:0];
			end else if (idx == IDX_CMP_LO) begin
				nxt_buf = pwdata[7:0];
			end else if (idx == IDX_CMP_HI) begin
				nxt_cmp = {pwdata[7:0], buf_ff};
			end else if (idx == IDX_PERIOD) begin
				nxt_period = pwdata[7:0];
			end else if (idx == IDX_AUX) begin
				nxt_pin_b_inv = pwdata[0];
			end
			// counter bytes have no write path
		end
		if (setup && !pwrite && map_ok(paddr)) begin
			// low byte is latched at the edge that samples the high byte, so a
			// running counter cannot carry between the two halves of one snapshot
			if (idx == IDX_CNT_HI) begin
				nxt_buf = cnt_ff[7:0];
			end else if (idx == IDX_CMP_HI) begin
				nxt_buf = cmp_ff[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_ff     <= CTRL0_RST;
			ctrl1_ff     <= CTRL1_RST;
			cmp_ff       <= CNT_RST;
			period_ff    <= BYTE_RST;
			buf_ff       <= BYTE_RST;
			pin_b_inv_ff <= 1'b0;
			prdata_ff    <= '0;
			err_ff       <= 1'b0;
		end else if (ce) begin
			ctrl0_ff     <= nxt_ctrl0;
			ctrl1_ff     <= nxt_ctrl1;
			cmp_ff       <= nxt_cmp;
			period_ff    <= nxt_period;
			buf_ff       <= nxt_buf;
			pin_b_inv_ff <= nxt_pin_b_inv;
			prdata_ff    <= nxt_prdata;
			err_ff       <= nxt_err;
		end
	end

	// tick selection; sources are strobes so the counter stays on pclk
	always_comb begin
		nxt_div4  = div4_ff + 2'h1;
		nxt_divh  = fh_tick ? divh_ff + 6'h01 : divh_ff;
		nxt_pin_d = external_clock_pin;
		case (ctrl0_ff.clock_select_field)
			CK_SYS_DIV4: tick = (div4_ff == DIV4_LAST);
			CK_SYS:      tick = 1'b1;
			CK_H_DIV16:  tick = fh_tick && ((divh_ff & DIV16_MASK) == DIV16_MASK);
			CK_H_DIV64:  tick = fh_tick && (divh_ff == DIV64_LAST);
			CK_TB_A:     tick = time_base_clock;
			CK_TB_B:     tick = time_base_clock;
			CK_PIN_RISE: tick = external_clock_pin && !pin_d_ff;
			default:     tick = !external_clock_pin && pin_d_ff;
		endcase
	end

	// counter, comparators and clearing
	assign on_rise = ctrl0_ff.on_off_bit && !on_prev_ff;
	assign run     = ctrl0_ff.on_off_bit && !ctrl0_ff.pause_bit && tick;
	assign cnt_inc = cnt_ff + 16'h0001; // wraps all ones to zero
	assign a_hit   = run && (cnt_ff == cmp_ff);
	// period match lands where the upper byte would reach the period
	assign p_hit   = run && (cnt_inc[15:8] == period_ff) && (cnt_inc[7:0] == BYTE_RST);
	assign do_clr  = ctrl1_ff.clear_select_bit ? a_hit : p_hit;

	always_comb begin
		nxt_on_prev = ctrl0_ff.on_off_bit;
		nxt_cnt     = cnt_ff;
		if (on_rise) begin
			nxt_cnt = CNT_RST;
		end else if (do_clr) begin
			nxt_cnt = CNT_RST;
		end else if (run) begin
			nxt_cnt = cnt_inc;
		end
		nxt_am  = a_hit;
		nxt_pm  = p_hit;
		nxt_irq = a_hit || p_hit;
		nxt_out = out_ff;
		if (ctrl1_ff.operating_mode_field == MODE_CMP_OUT) begin
			if (on_rise) begin
				nxt_out = ctrl1_ff.output_control_bit;
			end else if (a_hit) begin
				case (ctrl1_ff.output_function_field)
					OF_LOW:    nxt_out = 1'b0;
					OF_HIGH:   nxt_out = 1'b1;
					OF_TOGGLE: nxt_out = !out_ff;
					default:   nxt_out = out_ff;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff     <= CNT_RST;
			div4_ff    <= '0;
			divh_ff    <= '0;
			pin_d_ff   <= 1'b0;
			on_prev_ff <= 1'b0;
			out_ff     <= 1'b0;
			irq_ff     <= 1'b0;
			am_ff      <= 1'b0;
			pm_ff      <= 1'b0;
		end else if (ce) begin
			cnt_ff     <= nxt_cnt;
			div4_ff    <= nxt_div4;
			divh_ff    <= nxt_divh;
			pin_d_ff   <= nxt_pin_d;
			on_prev_ff <= nxt_on_prev;
			out_ff     <= nxt_out;
			irq_ff     <= nxt_irq;
			am_ff      <= nxt_am;
			pm_ff      <= nxt_pm;
		end
	end

	assign timer_irq   = irq_ff;
	assign cmp_a_match = am_ff;
	assign cmp_p_match = pm_ff;

	// pins: polarity applies except in timer/counter mode; pin b may be inverted
	logic [1:0] pin_w;
	logic       pol;
	assign pol = ctrl1_ff.output_polarity_bit && (ctrl1_ff.operating_mode_field != MODE_TIMER);
	for (genvar g = 0; g < 2; g++) begin : g_pin
		assign pin_w[g] = out_ff ^ pol ^ ((g == 1) && pin_b_inv_ff);
	end
	assign timer_output_pin_a = pin_w[0];
	assign timer_output_pin_b = pin_w[1];

	// checks
	property p_lo_write;
		ce && wr_acc && idx == IDX_CMP_LO |=> buf_ff == $past(pwdata[7:0]) && $stable(cmp_ff);
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("low write reached compare");

	property p_hi_write;
		ce && wr_acc && idx == IDX_CMP_HI |=> cmp_ff == {$past(pwdata[7:0]), $past(buf_ff)};
	endproperty
	a_hi_write: assert property (p_hi_write) else $error("high write pairing wrong");

	property p_hi_read;
		ce && setup && !pwrite && map_ok(paddr) && idx == IDX_CNT_HI
			|=> buf_ff == $past(cnt_ff[7:0]) && prdata[7:0] == $past(cnt_ff[15:8]);
	endproperty
	a_hi_read: assert property (p_hi_read) else $error("counter low not captured");

	property p_lo_read;
		psel && penable && !pwrite && map_ok(paddr) && idx == IDX_CNT_LO |-> prdata[7:0] == buf_ff;
	endproperty
	a_lo_read: assert property (p_lo_read) else $error("low read not from buffer");

	property p_hold;
		ce && !on_rise && (ctrl0_ff.pause_bit || !ctrl0_ff.on_off_bit) |=> $stable(cnt_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while held");

	property p_on_clear;
		ce && on_rise |=> cnt_ff == CNT_RST;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("on rise did not clear");

	property p_rsvd;
		psel && penable && !pwrite && map_ok(paddr) && idx == IDX_CTRL0 |-> prdata[2:0] == RSVD_ZERO;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

	property p_period_wrap;
		ce && run && !on_rise && !ctrl1_ff.clear_select_bit
			&& cnt_ff == {period_ff - 8'h01, 8'hFF} |=> cnt_ff == CNT_RST ##0 cmp_p_match;
	endproperty
	a_period_wrap: assert property (p_period_wrap) else $error("period clear missed");

	property p_cmp_clear;
		ce && run && !on_rise && ctrl1_ff.clear_select_bit && cnt_ff == cmp_ff
			|=> cnt_ff == CNT_RST && timer_irq;
	endproperty
	a_cmp_clear: assert property (p_cmp_clear) else $error("compare clear missed");

	property p_out_set;
		ce && a_hit && !on_rise && ctrl1_ff.operating_mode_field == MODE_CMP_OUT
			&& ctrl1_ff.output_function_field == OF_HIGH |=> out_ff;
	endproperty
	a_out_set: assert property (p_out_set) else $error("output not driven high");

	property p_out_low;
		ce && a_hit && !on_rise && ctrl1_ff.operating_mode_field == MODE_CMP_OUT
			&& ctrl1_ff.output_function_field == OF_LOW |=> !out_ff;
	endproperty
	a_out_low: assert property (p_out_low) else $error("output not driven low");

	property p_toggle;
		ce && a_hit && !on_rise && ctrl1_ff.operating_mode_field == MODE_CMP_OUT
			&& ctrl1_ff.output_function_field == OF_TOGGLE |=> out_ff != $past(out_ff);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output did not toggle");

	property p_cmp_hi_read;
		ce && setup && !pwrite && map_ok(paddr) && idx == IDX_CMP_HI
			|=> buf_ff == $past(cmp_ff[7:0]) && prdata[7:0] == $past(cmp_ff[15:8]);
	endproperty
	a_cmp_hi_read: assert property (p_cmp_hi_read) else $error("compare low not captured");

	property p_count;
		ce && run && !on_rise && !do_clr |=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter did not step up");

	property p_wrap;
		ce && run && !on_rise && cnt_ff == '1 |=> cnt_ff == CNT_RST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

	property p_pin_rise;
		ce && ctrl0_ff.on_off_bit && !ctrl0_ff.pause_bit && !on_rise && !do_clr
			&& ctrl0_ff.clock_select_field == CK_PIN_RISE && external_clock_pin && !pin_d_ff
			|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_pin_rise: assert property (p_pin_rise) else $error("pin rising edge not counted");

	property p_irq;
		ce && (a_hit || p_hit) |=> timer_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("match raised no interrupt pulse");

	property p_on_out;
		ce && on_rise && ctrl1_ff.operating_mode_field == MODE_CMP_OUT
			|=> out_ff == $past(ctrl1_ff.output_control_bit);
	endproperty
	a_on_out: assert property (p_on_out) else $error("initial output level not restored");

	property p_no_cnt_write;
		ce && wr_acc && (idx == IDX_CNT_LO || idx == IDX_CNT_HI) && !ctrl0_ff.on_off_bit
			|=> $stable(cnt_ff);
	endproperty
	a_no_cnt_write: assert property (p_no_cnt_write) else $error("counter took a write");

	property p_rsvd_store;
		ce && wr_acc && idx == IDX_CTRL0 |=> ctrl0_ff.rsvd == RSVD_ZERO;
	endproperty
	a_rsvd_store: assert property (p_rsvd_store) else $error("reserved bits stored");

	c_period: cover property (ce && p_hit && !ctrl1_ff.clear_select_bit);
	c_wrap:   cover property (ce && run && cnt_ff == '1);
	c_fall:   cover property (ce && run && ctrl0_ff.clock_select_field == CK_PIN_FALL);
	c_toggle: cover property (ce && a_hit && ctrl1_ff.output_function_field == OF_TOGGLE);
	c_pair:   cover property (rd_acc && idx == IDX_CNT_HI ##[1:8] rd_acc && idx == IDX_CNT_LO);
endmodule
`default_nettype wire

// >>> shared/stm_pkg.sv
// package: register map, field layouts, encodings and reset values of the standard timer
package stm_pkg;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_CTRL0  = 3'h0;
	localparam logic [2:0] IDX_CTRL1  = 3'h1;
	localparam logic [2:0] IDX_CNT_LO = 3'h2;
	localparam logic [2:0] IDX_CNT_HI = 3'h3;
	localparam logic [2:0] IDX_CMP_LO = 3'h4;
	localparam logic [2:0] IDX_CMP_HI = 3'h5;
	localparam logic [2:0] IDX_PERIOD = 3'h6;
	localparam logic [2:0] IDX_AUX    = 3'h7;
	localparam int         ADDR_W     = 12;
	localparam logic [1:0] WORD_LSB   = 2'h0;

	localparam logic [7:0]  CTRL0_RST  = 8'h00;
	localparam logic [7:0]  CTRL1_RST  = 8'h00;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [15:0] CNT_RST    = 16'h0000;
	localparam logic [2:0]  RSVD_ZERO  = 3'h0;
	localparam logic [1:0]  DIV4_LAST  = 2'h3;
	localparam logic [5:0]  DIV16_MASK = 6'h0F;
	localparam logic [5:0]  DIV64_LAST = 6'h3F;

	// clock select codes in documented order
	typedef enum logic [2:0] {
		CK_SYS_DIV4, CK_SYS, CK_H_DIV16, CK_H_DIV64, CK_TB_A, CK_TB_B, CK_PIN_RISE, CK_PIN_FALL
	} stm_clk_sel_e;

	typedef enum logic [1:0] {MODE_CMP_OUT, MODE_CAPTURE, MODE_PWM, MODE_TIMER} stm_mode_e;

	typedef enum logic [1:0] {OF_NONE, OF_LOW, OF_HIGH, OF_TOGGLE} stm_out_fn_e;

	typedef struct packed {
		logic         pause_bit;
		stm_clk_sel_e clock_select_field;
		logic         on_off_bit;
		logic [2:0]   rsvd;
	} stm_ctrl0_s;

	typedef struct packed {
		stm_mode_e   operating_mode_field;
		stm_out_fn_e output_function_field;
		logic        output_control_bit;
		logic        output_polarity_bit;
		logic        period_duty_swap_bit;
		logic        clear_select_bit;
	} stm_ctrl1_s;
endpackage

// >>> testbench/stm_far_side.sv
// far-side model: external clock pin and internal clock strobes feeding the timer
`timescale 1ns/1ns
`default_nettype none
module stm_far_side (
	input  wire logic pclk,
	output logic      external_clock_pin,
	output logic      time_base_clock,
	output logic      fh_tick
);
	// strobes stand still between bursts; the pin keeps its level like a real source
	initial begin
		external_clock_pin = 1'b0;
		time_base_clock = 1'b0;
		fh_tick = 1'b0;
	end
	// src 0 toggles the pin n times, 1 and 2 give n strobes, 3 only idles
	task automatic burst(input int src, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			if (src == 0) external_clock_pin <= ~external_clock_pin;
			if (src == 1) fh_tick <= 1'b1;
			if (src == 2) time_base_clock <= 1'b1;
			@(posedge pclk);
			fh_tick <= 1'b0;
			time_base_clock <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb_stm_timer.sv
// testbench: register, counter, compare and output checks of the standard timer
`timescale 1ns/1ns
`default_nettype none
module tb_stm_timer
	import stm_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, err, p1, ce_r;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, ext_pin, tb_clk, fh, pin_a, pin_b, irq, ma, mp;
	logic [15:0]       v, w;
	int                n_mismatch = 0, checks = 0, cyc = 0, t1, t2;
	// per clock code: stimulus source, burst length, expected ticks
	int                src [8] = '{3, 0, 1, 1, 2, 2, 0, 0};
	int                nb  [8] = '{20, 0, 32, 64, 5, 5, 5, 3};
	logic [15:0]       ex  [8] = '{16'h0, 16'h0, 16'h2, 16'h1, 16'h5, 16'h5, 16'h3, 16'h2};

	stm_timer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce_r), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fh_tick(fh),
		.time_base_clock(tb_clk), .external_clock_pin(ext_pin),
		.timer_output_pin_a(pin_a), .timer_output_pin_b(pin_b), .timer_irq(irq),
		.cmp_a_match(ma), .cmp_p_match(mp));
	stm_far_side far_u (.pclk(pclk), .external_clock_pin(ext_pin),
		.time_base_clock(tb_clk), .fh_tick(fh));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// hang guard: the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp=%h seen=%h", name, exp, seen);
		end
	endtask
	// apb transfer: held until pready is sampled high, data taken at that edge
	task automatic apb_a(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] d);
		apb_a(wr, {7'h00, idx, WORD_LSB}, d);
	endtask
	// high byte first so the low byte comes from the same snapshot
	task automatic rdcnt(output logic [15:0] c);
		apb(1'b0, IDX_CNT_HI, 8'h00);
		c[15:8] = rd[7:0];
		apb(1'b0, IDX_CNT_LO, 8'h00);
		c[7:0] = rd[7:0];
	endtask
	task automatic wait_pulse(input logic p, output int t);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while ((p ? mp : ma) !== 1'b1 && n < 600);
		t = cyc;
		check("match pulse", {31'h0, (p ? mp : ma)}, 32'h1);
		check("irq with match", {31'h0, irq}, 32'h1);
	endtask

	initial begin
		presetn = 1'b0;
		ce_r = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, i[2:0], 8'h00);
			check("reset value", rd, 32'h0);
		end
		apb_a(1'b0, 12'h020, 8'h00);
		check("unmapped", {rd[30:0], err}, 32'h1);
		apb_a(1'b1, 12'h002, 8'hFF);
		check("unaligned", {31'h0, err}, 32'h1);
		apb(1'b1, IDX_CTRL0, 8'h07);
		apb(1'b0, IDX_CTRL0, 8'h00);
		check("ctrl0 low bits", rd, 32'h0);
		// timer stays off while the mode field changes
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, IDX_CTRL1, {m[1:0], 6'h00});
			apb(1'b0, IDX_CTRL1, 8'h00);
			check("mode field", rd, {24'h0, m[1:0], 6'h00});
		end
		apb(1'b1, IDX_CTRL1, 8'h00);
		apb(1'b1, IDX_CMP_LO, 8'h34);
		apb(1'b0, IDX_CMP_HI, 8'h00);
		apb(1'b0, IDX_CMP_LO, 8'h00);
		check("low untouched", rd, 32'h0);
		apb(1'b1, IDX_CMP_LO, 8'h34);
		apb(1'b1, IDX_CMP_HI, 8'h12);
		apb(1'b0, IDX_CMP_HI, 8'h00);
		check("compare high", rd, 32'h12);
		apb(1'b0, IDX_CNT_HI, 8'h00);
		apb(1'b0, IDX_CMP_LO, 8'h00);
		check("shared buffer", rd, 32'h0);
		apb(1'b0, IDX_CMP_HI, 8'h00);
		apb(1'b0, IDX_CMP_LO, 8'h00);
		check("compare low", rd, 32'h34);
		apb(1'b1, IDX_PERIOD, 8'h01);
		apb(1'b0, IDX_PERIOD, 8'h00);
		check("period", rd, 32'h1);
		// every clock source except sys, which the compare runs below cover
		for (int c = 0; c < 8; c++) begin
			if (c != 1) begin
				apb(1'b1, IDX_CTRL0, 8'h00);
				apb(1'b1, IDX_CTRL0, {1'b0, c[2:0], 4'h8});
				repeat (3) @(posedge pclk);
				far_u.burst(src[c], nb[c]);
				rdcnt(v);
				if (c == 0) check("sys4 ticks", {31'h0, v > 16'd8 && v < 16'd13}, 32'h1);
				else check("ticks", {16'h0, v}, {16'h0, ex[c]});
			end
		end
		apb(1'b1, IDX_CTRL0, 8'h00);
		apb(1'b1, IDX_CMP_LO, 8'h09);
		apb(1'b1, IDX_CMP_HI, 8'h00);
		apb(1'b1, IDX_CTRL1, 8'h31);
		apb(1'b1, IDX_CTRL0, 8'h18);
		wait_pulse(1'b0, t1);
		repeat (3) @(posedge pclk);
		#1;
		p1 = pin_a;
		wait_pulse(1'b0, t2);
		check("compare cycle", 32'(t2 - t1), 32'd10);
		repeat (3) @(posedge pclk);
		#1;
		check("toggle", {31'h0, pin_a}, {31'h0, ~p1});
		check("pin copy", {31'h0, pin_b}, {31'h0, pin_a});
		apb(1'b1, IDX_AUX, 8'h01);
		#1;
		check("pin inverse", {31'h0, pin_b}, {31'h0, ~pin_a});
		apb(1'b1, IDX_CTRL0, 8'h98);
		rdcnt(v);
		rdcnt(w);
		check("paused", {16'h0, w}, {16'h0, v});
		apb(1'b1, IDX_CTRL0, 8'h18);
		wait_pulse(1'b0, t1);
		apb(1'b1, IDX_CTRL0, 8'h10);
		rdcnt(v);
		apb(1'b1, IDX_CNT_HI, 8'hFF);
		apb(1'b1, IDX_CNT_LO, 8'hFF);
		rdcnt(w);
		check("held and unwritable", {16'h0, w}, {16'h0, v});
		apb(1'b1, IDX_CTRL1, 8'h19);
		apb(1'b1, IDX_CTRL0, 8'h18);
		repeat (3) @(posedge pclk);
		#1;
		check("initial level", {31'h0, pin_a}, 32'h1);
		wait_pulse(1'b0, t1);
		repeat (3) @(posedge pclk);
		#1;
		check("driven low", {31'h0, pin_a}, 32'h0);
		apb(1'b1, IDX_CTRL0, 8'h10);
		apb(1'b1, IDX_CTRL1, 8'h00);
		apb(1'b1, IDX_CTRL0, 8'h18);
		wait_pulse(1'b1, t1);
		wait_pulse(1'b1, t2);
		check("period cycle", 32'(t2 - t1), 32'd256);
		// clock enable low for 50 edges stretches the next period by exactly that much
		@(posedge pclk);
		ce_r <= 1'b0;
		repeat (50) @(posedge pclk);
		ce_r <= 1'b1;
		wait_pulse(1'b1, t1);
		check("frozen period", 32'(t1 - t2), 32'd306);
		summarize();
	end
endmodule
`default_nettype wire
